//--- shared/cbcld_params.svh
`ifndef CBCLD_PARAMS_SVH
`define CBCLD_PARAMS_SVH
// top nibble groups
`define CBCLD_NIB_ORPHAN 4'hf
`define CBCLD_NIB_BIT_CLR 4'h9
`define CBCLD_NIB_BIT_SET 4'h8
`define CBCLD_NIB_BIT_INV 4'h7
`define CBCLD_NIB_SKIP_ZERO 4'hb
`define CBCLD_NIB_SKIP_ONE 4'ha
`define CBCLD_NIB_REL_JUMP 4'hd
`define CBCLD_NIB_LONG 4'he
`define CBCLD_NIB_LIT 4'h0
// second nibble within the 1110 group
`define CBCLD_SUB_COND_HI 1'b0
`define CBCLD_SUB_CALL 3'h6
`define CBCLD_SUB_ABS_JUMP 4'hf
`define CBCLD_SUB_PTR_LOAD 4'he
// second nibble within the literal group
`define CBCLD_LIT_ADD 4'hf
`define CBCLD_LIT_AND 4'hb
`define CBCLD_LIT_OR 4'h9
`define CBCLD_LIT_SUB 4'h8
`define CBCLD_LIT_XOR 4'ha
`define CBCLD_LIT_LOAD 4'he
`define CBCLD_LIT_MUL 4'hd
`define CBCLD_LIT_EXIT 4'hc
// whole control words
`define CBCLD_W_NOP 16'h0000
`define CBCLD_W_STANDBY 16'h0003
`define CBCLD_W_WDT_CLR 16'h0004
`define CBCLD_W_PUSH 16'h0005
`define CBCLD_W_POP 16'h0006
`define CBCLD_W_SWRESET 16'h00ff
`define CBCLD_W_IRQ_EXIT_HI 15'h0008
`define CBCLD_W_SUB_EXIT_HI 15'h0009
`define CBCLD_W_BANK_HI 12'h010
`define CBCLD_W_TBL_HI 13'h0001
// branch conditions
`define CBCLD_COND_ZERO 3'h0
`define CBCLD_COND_NONZERO 3'h1
`define CBCLD_COND_CARRY 3'h2
`define CBCLD_COND_NO_CARRY 3'h3
`define CBCLD_COND_OVF 3'h4
`define CBCLD_COND_NO_OVF 3'h5
`define CBCLD_COND_NEG 3'h6
`define CBCLD_COND_NON_NEG 3'h7
// status update masks, bit order {c, dc, z, ov, n}
`define CBCLD_FLAG_ARITH 5'h1f
`define CBCLD_FLAG_LOGIC 5'h05
`define CBCLD_FLAG_NONE 5'h00
// reset values
`define CBCLD_RST_READY 1'b1
`endif

//--- shared/cbcld_pkg.sv
package cbcld_pkg;
  // decoded operation classes
  typedef enum logic [4:0] {
    OP_NOP = 5'b00000,
    OP_BIT_CLR = 5'b00001,
    OP_BIT_SET = 5'b00010,
    OP_BIT_INV = 5'b00011,
    OP_SKIP_ZERO = 5'b00100,
    OP_SKIP_ONE = 5'b00101,
    OP_BRANCH_COND = 5'b00110,
    OP_REL_JUMP = 5'b00111,
    OP_REL_CALL = 5'b01000,
    OP_ABS_CALL = 5'b01001,
    OP_ABS_JUMP = 5'b01010,
    OP_WDT_CLR = 5'b01011,
    OP_STANDBY = 5'b01100,
    OP_PUSH = 5'b01101,
    OP_POP = 5'b01110,
    OP_SWRESET = 5'b01111,
    OP_IRQ_EXIT = 5'b10000,
    OP_EXIT_CONST = 5'b10001,
    OP_SUB_EXIT = 5'b10010,
    OP_C_ADD = 5'b10011,
    OP_C_AND = 5'b10100,
    OP_C_OR = 5'b10101,
    OP_C_SUB = 5'b10110,
    OP_C_XOR = 5'b10111,
    OP_C_LOAD = 5'b11000,
    OP_C_MUL = 5'b11001,
    OP_BANK_LOAD = 5'b11010,
    OP_PTR_LOAD = 5'b11011,
    OP_TBL_RD = 5'b11100,
    OP_TBL_WT = 5'b11101,
    OP_OTHER = 5'b11110
  } cbcld_op_e;
  // sequencer states
  typedef enum logic [2:0] {
    ST_EXEC = 3'b000,
    ST_WORD2 = 3'b001,
    ST_FLUSH = 3'b010,
    ST_SKIP = 3'b011,
    ST_SKIP2 = 3'b100,
    ST_HOLD = 3'b101
  } cbcld_state_e;
endpackage : cbcld_pkg

//--- design/cbcld_classify.sv
`include "cbcld_params.svh"
module cbcld_classify (
  // fetched word
  input wire logic [15:0] word,
  // decoded class
  output cbcld_pkg::cbcld_op_e op
);
  import cbcld_pkg::*;

  // pure pattern match on one word, no state
  always_comb
  begin
    op = OP_OTHER;
    case (word[15:12])
      `CBCLD_NIB_ORPHAN: op = OP_NOP;
      `CBCLD_NIB_BIT_CLR: op = OP_BIT_CLR;
      `CBCLD_NIB_BIT_SET: op = OP_BIT_SET;
      `CBCLD_NIB_BIT_INV: op = OP_BIT_INV;
      `CBCLD_NIB_SKIP_ZERO: op = OP_SKIP_ZERO;
      `CBCLD_NIB_SKIP_ONE: op = OP_SKIP_ONE;
      `CBCLD_NIB_REL_JUMP: op = word[11] ? OP_REL_CALL : OP_REL_JUMP;
      `CBCLD_NIB_LONG:
      begin
        if (word[11] == `CBCLD_SUB_COND_HI)
          op = OP_BRANCH_COND;
        else if (word[11:9] == `CBCLD_SUB_CALL)
          op = OP_ABS_CALL;
        else if (word[11:8] == `CBCLD_SUB_ABS_JUMP)
          op = OP_ABS_JUMP;
        else if (word[11:8] == `CBCLD_SUB_PTR_LOAD && word[7:6] == 2'h0)
          op = OP_PTR_LOAD;
      end
      `CBCLD_NIB_LIT:
      begin
        case (word[11:8])
          `CBCLD_LIT_ADD: op = OP_C_ADD;
          `CBCLD_LIT_AND: op = OP_C_AND;
          `CBCLD_LIT_OR: op = OP_C_OR;
          `CBCLD_LIT_SUB: op = OP_C_SUB;
          `CBCLD_LIT_XOR: op = OP_C_XOR;
          `CBCLD_LIT_LOAD: op = OP_C_LOAD;
          `CBCLD_LIT_MUL: op = OP_C_MUL;
          `CBCLD_LIT_EXIT: op = OP_EXIT_CONST;
          default:
          begin
            // whole-word control forms live under 0000 0000 and 0000 0001
            if (word == `CBCLD_W_NOP) op = OP_NOP;
            else if (word == `CBCLD_W_STANDBY) op = OP_STANDBY;
            else if (word == `CBCLD_W_WDT_CLR) op = OP_WDT_CLR;
            else if (word == `CBCLD_W_PUSH) op = OP_PUSH;
            else if (word == `CBCLD_W_POP) op = OP_POP;
            else if (word == `CBCLD_W_SWRESET) op = OP_SWRESET;
            else if (word[15:1] == `CBCLD_W_IRQ_EXIT_HI) op = OP_IRQ_EXIT;
            else if (word[15:1] == `CBCLD_W_SUB_EXIT_HI) op = OP_SUB_EXIT;
            else if (word[15:4] == `CBCLD_W_BANK_HI) op = OP_BANK_LOAD;
            else if (word[15:3] == `CBCLD_W_TBL_HI) op = word[2] ? OP_TBL_WT : OP_TBL_RD;
          end
        endcase
      end
      default: op = OP_OTHER;
    endcase
  end
endmodule : cbcld_classify

//--- design/cbcld_decode.sv
// Overview of operation
// - pc change or true test costs nop cycle, except absolute jump/call
// - orphan 1111 word runs as no-op
// - port read-modify-write reads sampled pins
// - writing timer-zero count clears assigned prescaler
// - bit clear, set, invert carry b,a,f fields
// - bit test skips, one cycle or two/three
// - eight conditional branches, one or two cycles
// - 11-bit relative jump or relative call
// - absolute call, two words, fast save bit
// - absolute jump, two words, two cycles
// - 0x0004 clears watchdog, updates expiry/powerdown
// - 0x0003 enters standby, updates expiry/powerdown
// - push and pop, one cycle, no flags
// - 0x00ff software reset of everything
// - interrupt exit re-enables both irq enables
// - exit with constant loads accumulator, two cycles
// - subroutine return, two cycles, fast restore
// - literal alu ops and their flag masks
// - literal load and multiply, no flags
// - long pointer load, two words, 12-bit literal
// - table reads, four pointer modes, two cycles
// - table writes, four pointer modes, two cycles
`include "cbcld_params.svh"
module cbcld_decode (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // fetch path
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  output logic word_ready_r,
  // datapath condition inputs
  input wire logic flag_c,
  input wire logic flag_z,
  input wire logic flag_ov,
  input wire logic flag_n,
  input wire logic file_bit_val,
  input wire logic port_reg_hit,
  input wire logic timer_zero_count_hit,
  input wire logic prescaler_assigned,
  // decoded instruction
  output cbcld_pkg::cbcld_op_e op_class_r,
  output logic exec_valid_r,
  output logic nop_cycle_r,
  output logic [2:0] bit_idx_r,
  output logic access_bank_r,
  output logic [7:0] file_addr_r,
  output logic [7:0] literal_r,
  output logic [10:0] branch_offset_r,
  output logic [19:0] target_r,
  output logic fast_r,
  output logic [1:0] ptr_sel_r,
  output logic [11:0] ptr_literal_r,
  output logic [1:0] tbl_mode_r,
  output logic [4:0] flag_mask_r,
  // control strobes
  output logic pc_load_r,
  output logic pc_rel_r,
  output logic pc_from_stack_r,
  output logic stack_push_r,
  output logic stack_pop_r,
  output logic wdt_clear_r,
  output logic standby_r,
  output logic sw_reset_r,
  output logic irq_en_set_r,
  output logic wd_pd_write_r,
  output logic watchdog_expiry_flag_r,
  output logic powerdown_flag_r,
  output logic read_pins_r,
  output logic prescaler_clear_r
);
  import cbcld_pkg::*;

  // branch condition test, shared by the sequencer and its checks
  function automatic logic cond_true(input logic [2:0] cc, input logic c, input logic z,
                                     input logic ov, input logic n);
    logic r;
    r = 1'b0;
    case (cc)
      `CBCLD_COND_ZERO: r = z;
      `CBCLD_COND_NONZERO: r = !z;
      `CBCLD_COND_CARRY: r = c;
      `CBCLD_COND_NO_CARRY: r = !c;
      `CBCLD_COND_OVF: r = ov;
      `CBCLD_COND_NO_OVF: r = !ov;
      `CBCLD_COND_NEG: r = n;
      default: r = !n;
    endcase
    return r;
  endfunction : cond_true

  // true for first words that own the following word
  function automatic logic is_two_word(input cbcld_op_e o);
    return (o == OP_ABS_CALL) || (o == OP_ABS_JUMP) || (o == OP_PTR_LOAD);
  endfunction : is_two_word

  cbcld_state_e state_r, state_nxt; // sequencer
  cbcld_op_e cls; // class of the incoming word
  logic [15:0] first_r, first_nxt; // held first word of a pair
  logic fire; // a word is consumed this cycle
  logic rst_int; // pin reset or the software reset strobe
  logic bit_write; // read-modify-write bit operation
  logic word_ready_nxt, exec_valid_nxt, nop_cycle_nxt, access_bank_nxt, fast_nxt;
  cbcld_op_e op_class_nxt;
  logic [2:0] bit_idx_nxt;
  logic [7:0] file_addr_nxt, literal_nxt;
  logic [10:0] branch_offset_nxt;
  logic [19:0] target_nxt;
  logic [1:0] ptr_sel_nxt, tbl_mode_nxt;
  logic [11:0] ptr_literal_nxt;
  logic [4:0] flag_mask_nxt;
  logic pc_load_nxt, pc_rel_nxt, pc_from_stack_nxt, stack_push_nxt, stack_pop_nxt;
  logic wdt_clear_nxt, standby_nxt, sw_reset_nxt, irq_en_set_nxt, wd_pd_write_nxt;
  logic watchdog_expiry_flag_nxt, powerdown_flag_nxt, read_pins_nxt, prescaler_clear_nxt;

  cbcld_classify u_classify (
    .word(instr_word),
    .op(cls)
  );

  assign fire = instr_valid && word_ready_r;
  assign rst_int = !resetn || sw_reset_r;
  assign bit_write = (cls == OP_BIT_CLR) || (cls == OP_BIT_SET) || (cls == OP_BIT_INV);

  // sequencer and decoded outputs; strobes default to idle every cycle
  always_comb
  begin
    state_nxt = state_r;
    first_nxt = first_r;
    op_class_nxt = op_class_r;
    exec_valid_nxt = 1'b0;
    nop_cycle_nxt = 1'b0;
    bit_idx_nxt = bit_idx_r;
    access_bank_nxt = access_bank_r;
    file_addr_nxt = file_addr_r;
    literal_nxt = literal_r;
    branch_offset_nxt = branch_offset_r;
    target_nxt = target_r;
    fast_nxt = fast_r;
    ptr_sel_nxt = ptr_sel_r;
    ptr_literal_nxt = ptr_literal_r;
    tbl_mode_nxt = tbl_mode_r;
    flag_mask_nxt = `CBCLD_FLAG_NONE;
    pc_load_nxt = 1'b0;
    pc_rel_nxt = 1'b0;
    pc_from_stack_nxt = 1'b0;
    stack_push_nxt = 1'b0;
    stack_pop_nxt = 1'b0;
    wdt_clear_nxt = 1'b0;
    standby_nxt = 1'b0;
    sw_reset_nxt = 1'b0;
    irq_en_set_nxt = 1'b0;
    wd_pd_write_nxt = 1'b0;
    watchdog_expiry_flag_nxt = watchdog_expiry_flag_r;
    powerdown_flag_nxt = powerdown_flag_r;
    read_pins_nxt = 1'b0;
    prescaler_clear_nxt = 1'b0;
    case (state_r)
      ST_EXEC:
      begin
        if (fire)
        begin
          op_class_nxt = cls;
          exec_valid_nxt = 1'b1;
          // operand fields are split on every word; unused ones are don't-care
          bit_idx_nxt = instr_word[11:9];
          access_bank_nxt = instr_word[8];
          file_addr_nxt = instr_word[7:0];
          literal_nxt = instr_word[7:0];
          fast_nxt = instr_word[0];
          tbl_mode_nxt = instr_word[1:0];
          case (cls)
            OP_BIT_CLR, OP_BIT_SET, OP_BIT_INV:
            begin
              // pins, not the output latch, feed the write-back of a port
              read_pins_nxt = port_reg_hit;
              prescaler_clear_nxt = timer_zero_count_hit && prescaler_assigned;
            end
            OP_SKIP_ZERO, OP_SKIP_ONE:
            begin
              if (file_bit_val == (cls == OP_SKIP_ONE))
                state_nxt = ST_SKIP;
            end
            OP_BRANCH_COND:
            begin
              branch_offset_nxt = {{3{instr_word[7]}}, instr_word[7:0]};
              if (cond_true(instr_word[10:8], flag_c, flag_z, flag_ov, flag_n))
              begin
                pc_rel_nxt = 1'b1;
                state_nxt = ST_FLUSH;
              end
            end
            OP_REL_JUMP, OP_REL_CALL:
            begin
              branch_offset_nxt = instr_word[10:0];
              pc_rel_nxt = 1'b1;
              stack_push_nxt = (cls == OP_REL_CALL);
              state_nxt = ST_FLUSH;
            end
            OP_ABS_CALL, OP_ABS_JUMP, OP_PTR_LOAD:
            begin
              // the pair completes on the next word; nothing acts yet
              exec_valid_nxt = 1'b0;
              first_nxt = instr_word;
              state_nxt = ST_WORD2;
            end
            OP_WDT_CLR:
            begin
              wdt_clear_nxt = 1'b1;
              wd_pd_write_nxt = 1'b1;
              watchdog_expiry_flag_nxt = 1'b1;
              powerdown_flag_nxt = 1'b1;
            end
            OP_STANDBY:
            begin
              standby_nxt = 1'b1;
              wd_pd_write_nxt = 1'b1;
              watchdog_expiry_flag_nxt = 1'b1;
              powerdown_flag_nxt = 1'b0;
            end
            OP_PUSH: stack_push_nxt = 1'b1;
            OP_POP: stack_pop_nxt = 1'b1;
            OP_SWRESET: sw_reset_nxt = 1'b1;
            OP_IRQ_EXIT, OP_SUB_EXIT, OP_EXIT_CONST:
            begin
              pc_from_stack_nxt = 1'b1;
              irq_en_set_nxt = (cls == OP_IRQ_EXIT);
              state_nxt = ST_FLUSH;
            end
            OP_C_ADD, OP_C_SUB: flag_mask_nxt = `CBCLD_FLAG_ARITH;
            OP_C_AND, OP_C_OR, OP_C_XOR: flag_mask_nxt = `CBCLD_FLAG_LOGIC;
            OP_BANK_LOAD: literal_nxt = {4'h0, instr_word[3:0]};
            OP_TBL_RD, OP_TBL_WT: state_nxt = ST_HOLD;
            default: ; // nop, literal load/multiply and byte ops need no strobe
          endcase
        end
      end
      ST_WORD2:
      begin
        if (fire)
        begin
          // second word is always consumed as operand bits of the pair
          op_class_nxt = (first_r[11:8] == `CBCLD_SUB_ABS_JUMP) ? OP_ABS_JUMP :
                         (first_r[11:8] == `CBCLD_SUB_PTR_LOAD) ? OP_PTR_LOAD : OP_ABS_CALL;
          exec_valid_nxt = 1'b1;
          target_nxt = {instr_word[11:0], first_r[7:0]};
          fast_nxt = first_r[8];
          ptr_sel_nxt = first_r[5:4];
          ptr_literal_nxt = {first_r[3:0], instr_word[7:0]};
          pc_load_nxt = (first_r[11:8] != `CBCLD_SUB_PTR_LOAD);
          stack_push_nxt = (first_r[11:9] == `CBCLD_SUB_CALL);
          state_nxt = ST_EXEC;
        end
      end
      ST_SKIP:
      begin
        if (fire)
        begin
          // a skipped pair costs one more discarded word
          nop_cycle_nxt = 1'b1;
          state_nxt = is_two_word(cls) ? ST_SKIP2 : ST_EXEC;
        end
      end
      ST_FLUSH, ST_SKIP2:
      begin
        if (fire)
        begin
          nop_cycle_nxt = 1'b1;
          state_nxt = ST_EXEC;
        end
      end
      ST_HOLD:
      begin
        // table access owns the bus for one cycle; fetch waits
        nop_cycle_nxt = 1'b1;
        state_nxt = ST_EXEC;
      end
      default: state_nxt = ST_EXEC;
    endcase
    word_ready_nxt = (state_nxt != ST_HOLD);
  end

  // registers; the software reset acts one cycle after its strobe
  always_ff @(posedge clk_sys)
  begin
    if (rst_int)
    begin
      state_r <= ST_EXEC;
      first_r <= 16'h0000;
      word_ready_r <= `CBCLD_RST_READY;
      op_class_r <= OP_NOP;
      exec_valid_r <= 1'b0;
      nop_cycle_r <= 1'b0;
      bit_idx_r <= 3'h0;
      access_bank_r <= 1'b0;
      file_addr_r <= 8'h00;
      literal_r <= 8'h00;
      branch_offset_r <= 11'h000;
      target_r <= 20'h00000;
      fast_r <= 1'b0;
      ptr_sel_r <= 2'h0;
      ptr_literal_r <= 12'h000;
      tbl_mode_r <= 2'h0;
      flag_mask_r <= `CBCLD_FLAG_NONE;
      pc_load_r <= 1'b0;
      pc_rel_r <= 1'b0;
      pc_from_stack_r <= 1'b0;
      stack_push_r <= 1'b0;
      stack_pop_r <= 1'b0;
      wdt_clear_r <= 1'b0;
      standby_r <= 1'b0;
      sw_reset_r <= 1'b0;
      irq_en_set_r <= 1'b0;
      wd_pd_write_r <= 1'b0;
      watchdog_expiry_flag_r <= 1'b0;
      powerdown_flag_r <= 1'b0;
      read_pins_r <= 1'b0;
      prescaler_clear_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      first_r <= first_nxt;
      word_ready_r <= word_ready_nxt;
      op_class_r <= op_class_nxt;
      exec_valid_r <= exec_valid_nxt;
      nop_cycle_r <= nop_cycle_nxt;
      bit_idx_r <= bit_idx_nxt;
      access_bank_r <= access_bank_nxt;
      file_addr_r <= file_addr_nxt;
      literal_r <= literal_nxt;
      branch_offset_r <= branch_offset_nxt;
      target_r <= target_nxt;
      fast_r <= fast_nxt;
      ptr_sel_r <= ptr_sel_nxt;
      ptr_literal_r <= ptr_literal_nxt;
      tbl_mode_r <= tbl_mode_nxt;
      flag_mask_r <= flag_mask_nxt;
      pc_load_r <= pc_load_nxt;
      pc_rel_r <= pc_rel_nxt;
      pc_from_stack_r <= pc_from_stack_nxt;
      stack_push_r <= stack_push_nxt;
      stack_pop_r <= stack_pop_nxt;
      wdt_clear_r <= wdt_clear_nxt;
      standby_r <= standby_nxt;
      sw_reset_r <= sw_reset_nxt;
      irq_en_set_r <= irq_en_set_nxt;
      wd_pd_write_r <= wd_pd_write_nxt;
      watchdog_expiry_flag_r <= watchdog_expiry_flag_nxt;
      powerdown_flag_r <= powerdown_flag_nxt;
      read_pins_r <= read_pins_nxt;
      prescaler_clear_r <= prescaler_clear_nxt;
    end
  end

  // checks on the sequencer
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst_int);

  a_orphan_word_nop: assert property (fire && state_r == ST_EXEC && instr_word[15:12] == `CBCLD_NIB_ORPHAN
    |=> exec_valid_r && op_class_r == OP_NOP && !pc_load_r && !pc_rel_r) else $error("orphan word not a no-op");
  a_flush_discards_word: assert property (state_r == ST_FLUSH && fire
    |=> nop_cycle_r && !exec_valid_r && state_r == ST_EXEC) else $error("flush cycle did not discard");
  a_taken_branch_flush: assert property (fire && state_r == ST_EXEC && cls == OP_BRANCH_COND
    && cond_true(instr_word[10:8], flag_c, flag_z, flag_ov, flag_n)
    |=> pc_rel_r && state_r == ST_FLUSH) else $error("taken branch not two cycles");
  a_untaken_branch_one: assert property (fire && state_r == ST_EXEC && cls == OP_BRANCH_COND
    && !cond_true(instr_word[10:8], flag_c, flag_z, flag_ov, flag_n)
    |=> !pc_rel_r && state_r == ST_EXEC) else $error("untaken branch redirected");
  a_skip_pair_three: assert property (state_r == ST_SKIP && fire && is_two_word(cls)
    |=> state_r == ST_SKIP2 ##0 nop_cycle_r) else $error("skipped pair not discarded whole");
  a_skip_on_bit: assert property (fire && state_r == ST_EXEC && cls == OP_SKIP_ZERO && !file_bit_val
    |=> state_r == ST_SKIP) else $error("clear bit did not skip");
  a_call_target_word: assert property (state_r == ST_WORD2 && fire && first_r[11:9] == `CBCLD_SUB_CALL
    |=> pc_load_r && stack_push_r && target_r == {$past(instr_word[11:0]), $past(first_r[7:0])})
    else $error("call target wrong");
  a_watchdog_clear_flags: assert property (fire && state_r == ST_EXEC && instr_word == `CBCLD_W_WDT_CLR
    |=> wdt_clear_r && wd_pd_write_r && watchdog_expiry_flag_r && powerdown_flag_r) else $error("watchdog clear");
  a_standby_flags: assert property (fire && state_r == ST_EXEC && instr_word == `CBCLD_W_STANDBY
    |=> standby_r && wd_pd_write_r && !powerdown_flag_r) else $error("standby flags wrong");
  a_prescaler_clear: assert property (fire && state_r == ST_EXEC && bit_write && timer_zero_count_hit
    && prescaler_assigned |=> prescaler_clear_r) else $error("prescaler not cleared");
  a_table_hold_cycle: assert property (exec_valid_r && op_class_r == OP_TBL_RD
    |-> !word_ready_r ##1 word_ready_r && nop_cycle_r) else $error("table read not two cycles");
  a_port_pins_read: assert property (fire && state_r == ST_EXEC && bit_write
    |=> read_pins_r == $past(port_reg_hit)) else $error("port write-back source wrong");

  c_taken_branch: cover property (pc_rel_r && op_class_r == OP_BRANCH_COND);
  c_skip_pair: cover property (state_r == ST_SKIP2);
  c_abs_call: cover property (pc_load_r && stack_push_r);
  c_table_write: cover property (exec_valid_r && op_class_r == OP_TBL_WT);
endmodule : cbcld_decode

//--- dv/cbcld_fetch_model.sv
// program memory fetch path feeding the decoder
module cbcld_fetch_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // handshake with the decoder
  input wire logic word_ready_r,
  output logic [15:0] instr_word,
  output logic instr_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] fetch_q[$]; // words waiting, filled by the bench
  initial
  begin
    instr_word = 16'h0000;
    instr_valid = 1'b0;
  end
  // a word leaves only at the edge that takes it; idle bus flips to the complement of its last word each cycle
  always @(posedge clk_sys)
  begin
    if (resetn && instr_valid && word_ready_r)
      void'(fetch_q.pop_front());
    #2;
    instr_valid = fetch_q.size() != 0;
    instr_word = instr_valid ? fetch_q[0] : ~instr_word;
  end
endmodule : cbcld_fetch_model

//--- dv/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import cbcld_pkg::*;
  logic clk_sys, resetn, instr_valid, word_ready_r, flag_c, flag_z, flag_ov, flag_n, file_bit_val;
  logic port_reg_hit, timer_zero_count_hit, prescaler_assigned, exec_valid_r, nop_cycle_r, access_bank_r, fast_r;
  logic pc_load_r, pc_rel_r, pc_from_stack_r, stack_push_r, stack_pop_r, wdt_clear_r, standby_r;
  logic sw_reset_r, irq_en_set_r, wd_pd_write_r, watchdog_expiry_flag_r, powerdown_flag_r, t;
  logic read_pins_r, prescaler_clear_r;
  logic [15:0] instr_word;
  logic [2:0] bit_idx_r;
  logic [7:0] file_addr_r, literal_r;
  logic [10:0] branch_offset_r;
  logic [19:0] target_r;
  logic [1:0] ptr_sel_r, tbl_mode_r;
  logic [11:0] ptr_literal_r;
  logic [4:0] flag_mask_r;
  cbcld_op_e op_class_r;
  logic [31:0] r;
  int bad_count, total_checks, cyc, n, i;
  // literal and control tables, in enum order
  logic [3:0] lit_nib[7] = '{4'hf, 4'hb, 4'h9, 4'h8, 4'ha, 4'he, 4'hd};
  logic [15:0] ctl_w[7] = '{16'h0004, 16'h0003, 16'h0005, 16'h0006, 16'h0011, 16'h0012, 16'h0105};
  cbcld_op_e ctl_op[7] = '{OP_WDT_CLR, OP_STANDBY, OP_PUSH, OP_POP, OP_IRQ_EXIT, OP_SUB_EXIT, OP_BANK_LOAD};
  logic [5:0] ctl_s[7] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h03, 6'h01, 6'h00};
  cbcld_decode cbcld_decode_inst (.*);
  cbcld_fetch_model cbcld_fetch_model_inst (.*);
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // hang guard, far above the several hundred cycles the run needs
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // expected branch outcome from the condition code and the flags {c, z, ov, n}
  function automatic logic want_taken(input int cc, input logic [3:0] f);
    return (cc < 2 ? f[2] : cc < 4 ? f[3] : cc < 6 ? f[1] : f[0]) ^ cc[0];
  endfunction : want_taken
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // inputs change and outputs are read 2 ns after the rising edge
  task automatic tick();
    @(posedge clk_sys);
    #2;
  endtask : tick
  // two words then two padding words; wait for the first executed class
  task automatic run(input logic [15:0] w1, input logic [15:0] w2, input cbcld_op_e e);
    int k;
    cbcld_fetch_model_inst.fetch_q = '{w1, w2, 16'h0000, 16'h0000};
    for (k = 0; k < 8 && exec_valid_r !== 1'b1; k++)
      tick();
    chk(op_class_r, e);
  endtask : run
  // count discarded cycles over the next seven cycles
  task automatic drain(input int e);
    int k;
    n = 0;
    for (k = 0; k < 7; k++)
    begin
      tick();
      n += nop_cycle_r === 1'b1;
    end
    chk(n, e);
  endtask : drain
  task automatic give_verdict();
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  initial
  begin
    r = 32'h0915;
    resetn = 1'b0;
    {flag_c, flag_z, flag_ov, flag_n, file_bit_val, port_reg_hit, timer_zero_count_hit, prescaler_assigned} = 8'h00;
    repeat (8) @(posedge clk_sys);
    #2;
    resetn = 1'b1;
    for (i = 0; i < 3; i++)
    begin
      r = xs(r);
      // hand corner: the first bit op always lands on a port register
      {port_reg_hit, timer_zero_count_hit, prescaler_assigned} = r[31:29] | {i == 0, 2'b00};
      run({4'h9 - 4'(i), r[11:0]}, 16'h0000, cbcld_op_e'(OP_BIT_CLR + i));
      chk({bit_idx_r, access_bank_r, file_addr_r}, r[11:0]);
      chk(read_pins_r, r[31] | (i == 0));
      chk(prescaler_clear_r, r[30] & r[29]);
      drain(0);
    end
    for (i = 0; i < 7; i++)
    begin
      r = xs(r);
      run({4'h0, lit_nib[i], r[7:0]}, 16'h0000, cbcld_op_e'(OP_C_ADD + i));
      chk(literal_r, r[7:0]);
      chk(flag_mask_r, i == 0 || i == 3 ? 5'h1f : i < 5 ? 5'h05 : 5'h00);
      drain(0);
      run(ctl_w[i], 16'h0000, ctl_op[i]);
      chk({wdt_clear_r, standby_r, stack_push_r, stack_pop_r, irq_en_set_r, pc_from_stack_r}, ctl_s[i]);
      if (i < 2)
        chk({wd_pd_write_r, watchdog_expiry_flag_r, powerdown_flag_r}, {2'b11, ~i[0]});
      chk(flag_mask_r, 5'h00);
      if (i == 6)
        chk(literal_r, 8'h05);
      if (i == 4 || i == 5)
        chk(fast_r, i == 4);
      drain(i == 4 || i == 5);
    end
    run({8'h0c, r[15:8]}, 16'h0000, OP_EXIT_CONST);
    chk({literal_r, pc_from_stack_r}, {r[15:8], 1'b1});
    drain(1);
    for (i = 0; i < 8; i++)
    begin
      r = xs(r);
      {flag_c, flag_z, flag_ov, flag_n} = r[11:8];
      t = want_taken(i, r[11:8]);
      run({8'he0 | 8'(i), r[7:0]}, 16'h0000, OP_BRANCH_COND);
      chk({pc_rel_r, branch_offset_r}, {t, {3{r[7]}}, r[7:0]});
      drain(t);
      run(i[0] ? {8'hef, r[7:0]} : {7'h76, r[8], r[7:0]}, {4'hf, r[19:8]}, i[0] ? OP_ABS_JUMP : OP_ABS_CALL);
      chk({target_r, pc_load_r, stack_push_r, fast_r}, {r[19:0], 1'b1, ~i[0], i[0] | r[8]});
      drain(0);
      run({4'hd, i[0], r[10:0]}, 16'h0000, i[0] ? OP_REL_CALL : OP_REL_JUMP);
      chk({branch_offset_r, stack_push_r}, {r[10:0], i[0]});
      drain(1);
      run(16'h0008 + 16'(i), 16'h0000, i < 4 ? OP_TBL_RD : OP_TBL_WT);
      chk({word_ready_r, tbl_mode_r}, {1'b0, i[1:0]});
      drain(1);
    end
    run({10'h3b8, r[5:4], r[11:8]}, {8'hf0, r[7:0]}, OP_PTR_LOAD);
    chk({ptr_sel_r, ptr_literal_r}, {r[5:4], r[11:0]});
    drain(0);
    for (i = 0; i < 6; i++)
    begin
      r = xs(r);
      // hand corners: bit held clear for the pair cases, so one pair is skipped and one runs
      file_bit_val = r[12] & !i[1];
      t = file_bit_val ^ ~i[0];
      run({4'hb - 4'(i[0]), r[11:0]}, i[1] ? 16'hef12 : 16'h0000, i[0] ? OP_SKIP_ONE : OP_SKIP_ZERO);
      drain(t * (1 + i[1]));
    end
    run({4'hf, r[11:0]}, 16'h0000, OP_NOP);
    drain(0);
    run(16'h00ff, 16'h0000, OP_SWRESET);
    chk(sw_reset_r, 1'b1);
    tick();
    chk({op_class_r, word_ready_r, exec_valid_r, target_r}, {OP_NOP, 2'b10, 20'h00000});
    drain(0);
    give_verdict();
  end
endmodule : tb_top
